// ==== hw/cmis_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef CMIS_CFG_SVH
`define CMIS_CFG_SVH
`define CMIS_OFF_MUL_CTRL 12'h000
`define CMIS_OFF_OSC_CTRL 12'h004
`define CMIS_OFF_STATUS 12'h008
`define CMIS_MUL_CTRL_RST 32'h0000_0000
`define CMIS_OSC_CTRL_RST 32'h0000_0000
`define CMIS_MUL_EN_BIT 7
`define CMIS_MUL_INIT_BIT 6
`define CMIS_MUL_RDY_BIT 5
`define CMIS_MUL_SCALE_LSB 2
`define CMIS_MUL_SEL_LSB 0
`define CMIS_OSC_MODE_LSB 4
`define CMIS_OSC_FREQ_LSB 0
`define CMIS_OSC_VALID_BIT 7
`define CMIS_SETTLE_NS 2000
`define CMIS_CLK_NS 8
`define CMIS_SETTLE_CYC ((`CMIS_SETTLE_NS + `CMIS_CLK_NS - 1) / `CMIS_CLK_NS)
`endif

// ==== hw/cmis_pkg.sv ====
// Types shared by the clock multiplier input select block
package cmis_pkg;
   typedef enum logic [1:0] {
      CMIS_SEL_INT_X2 = 2'b00,
      CMIS_SEL_EXT_X2 = 2'b01,
      CMIS_SEL_INT_X4 = 2'b10,
      CMIS_SEL_EXT_X4 = 2'b11
   } cmis_sel_e;
   typedef enum logic [1:0] {
      CMIS_ST_OFF = 2'b00,
      CMIS_ST_WAIT = 2'b01,
      CMIS_ST_SETTLE = 2'b10,
      CMIS_ST_READY = 2'b11
   } cmis_state_e;
   typedef struct packed {
      logic enable;
      logic init;
      logic [2:0] scale;
      cmis_sel_e sel;
   } cmis_mul_cfg_s;
   typedef struct packed {
      logic use_ext;
      logic [2:0] mult;
      logic [2:0] num;
      logic [2:0] den;
   } cmis_route_s;
   typedef struct packed {
      logic first_claim;
      logic second_claim;
   } cmis_pins_s;
endpackage

// ==== hw/cmis_route.sv ====
// Decodes input select and output scale into source, factor and ratio
`timescale 1ns/1ns
`default_nettype none
module cmis_route (
   input wire cmis_pkg::cmis_mul_cfg_s cfg_i,
   output cmis_pkg::cmis_route_s route_o
);
   import cmis_pkg::*;
   always_comb begin
      route_o.use_ext = cfg_i.sel[0];
      route_o.mult = cfg_i.sel[1] ? 3'h4 : 3'h2;
      route_o.num = 3'h1;
      route_o.den = 3'h1;
      if (cfg_i.sel != CMIS_SEL_INT_X2) begin
         unique case (cfg_i.scale)
            3'h3: begin
               route_o.num = 3'h2;
               route_o.den = 3'h3;
            end
            3'h4: begin
               route_o.num = 3'h1;
               route_o.den = 3'h2;
            end
            3'h5: begin
               route_o.num = 3'h2;
               route_o.den = 3'h5;
            end
            3'h6: begin
               route_o.num = 3'h1;
               route_o.den = 3'h3;
            end
            3'h7: begin
               route_o.num = 3'h2;
               route_o.den = 3'h7;
            end
            default: begin
               route_o.num = 3'h1;
               route_o.den = 3'h1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== hw/cmis_top.sv ====
// Clock multiplier input select, pin takeover and AHB-Lite registers
//
// Functional notes
// - Select 00 feeds internal oscillator doubled, scale at unity.
// - Select 01 feeds external oscillator doubled, then scaled.
// - Select 10 feeds internal oscillator quadrupled, then scaled.
// - Select 11 feeds external oscillator quadrupled, then scaled.
// - Internal doubled ignores the output scale field entirely.
// - Crystal mode enabled claims first and second oscillator pins.
// - Capacitor, RC or CMOS mode claims only the second pin.
// - After enable, writing init starts settle; ready set when stable.
// - Scale codes 000-010 unity; 011-111 give 2/3,1/2,2/5,1/3,2/7.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`include "cmis_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module cmis_top (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic ext_osc_valid_i,
   output logic mul_enable_o,
   output logic mul_use_ext_o,
   output logic [2:0] mul_factor_o,
   output logic [2:0] scale_num_o,
   output logic [2:0] scale_den_o,
   output cmis_pkg::cmis_pins_s pin_claim_o,
   output logic [2:0] osc_mode_o,
   output logic [2:0] osc_freq_o
);
   import cmis_pkg::*;

   localparam int SETTLE_CYC = `CMIS_SETTLE_CYC;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic wr_pend_reg;
   logic [11:0] addr_reg;
   logic [7:0] mul_ctrl_reg;
   logic [5:0] osc_ctrl_reg;
   cmis_state_e state_reg;
   logic [15:0] cnt_reg;
   logic valid_s1_reg;
   logic valid_s2_reg;
   logic [31:0] rdata_next;
   logic init_wr;
   logic ready;
   cmis_mul_cfg_s cfg;
   cmis_route_s route;

   wire addr_ph = hsel_i && hready_i && htrans_i[1];

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 12'h000;
      end else if (hready_i) begin
         wr_pend_reg <= addr_ph && hwrite_i;
         addr_reg <= haddr_i[11:0];
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   wire wr_mul = wr_pend_reg && addr_reg == `CMIS_OFF_MUL_CTRL;
   wire wr_osc = wr_pend_reg && addr_reg == `CMIS_OFF_OSC_CTRL;
   assign init_wr = wr_mul && hwdata_i[`CMIS_MUL_INIT_BIT]
      && mul_ctrl_reg[`CMIS_MUL_EN_BIT];

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mul_ctrl_reg <= 8'h00;
      end else if (wr_mul) begin
         mul_ctrl_reg <= hwdata_i[7:0];
      end
   end

   // Oscillator type and frequency control, bit 3 reads zero
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_ctrl_reg <= 6'h00;
      end else if (wr_osc) begin
         osc_ctrl_reg <= {hwdata_i[6:4], hwdata_i[2:0]};
      end
   end

   // Decoded from the address phase so the word stands in the data phase
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (haddr_i[11:0] == `CMIS_OFF_MUL_CTRL) begin
         rdata_next[7:0] = mul_ctrl_reg;
         rdata_next[`CMIS_MUL_RDY_BIT] = ready;
      end else if (haddr_i[11:0] == `CMIS_OFF_OSC_CTRL) begin
         rdata_next[6:4] = osc_ctrl_reg[5:3];
         rdata_next[2:0] = osc_ctrl_reg[2:0];
         rdata_next[`CMIS_OSC_VALID_BIT] = valid_s2_reg
            && osc_ctrl_reg[5:4] == 2'b11;
      end else if (haddr_i[11:0] == `CMIS_OFF_STATUS) begin
         rdata_next[1:0] = state_reg;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_ph && !hwrite_i) begin
         hrdata_o <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Oscillator valid synchroniser
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         valid_s1_reg <= 1'b0;
         valid_s2_reg <= 1'b0;
      end else begin
         valid_s1_reg <= ext_osc_valid_i;
         valid_s2_reg <= valid_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Multiplier lock sequence
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= CMIS_ST_OFF;
         cnt_reg <= 16'h0000;
      end else if (!mul_ctrl_reg[`CMIS_MUL_EN_BIT]) begin
         state_reg <= CMIS_ST_OFF;
         cnt_reg <= 16'h0000;
      end else begin
         unique case (state_reg)
            CMIS_ST_OFF: begin
               if (init_wr) begin
                  state_reg <= CMIS_ST_SETTLE;
                  cnt_reg <= 16'(SETTLE_CYC - 1);
               end else begin
                  state_reg <= CMIS_ST_WAIT;
               end
            end
            CMIS_ST_WAIT: begin
               if (init_wr) begin
                  state_reg <= CMIS_ST_SETTLE;
                  cnt_reg <= 16'(SETTLE_CYC - 1);
               end
            end
            CMIS_ST_SETTLE: begin
               if (init_wr) begin
                  cnt_reg <= 16'(SETTLE_CYC - 1);
               end else if (cnt_reg == 16'h0000) begin
                  state_reg <= CMIS_ST_READY;
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            CMIS_ST_READY: begin
               if (init_wr) begin
                  state_reg <= CMIS_ST_SETTLE;
                  cnt_reg <= 16'(SETTLE_CYC - 1);
               end
            end
         endcase
      end
   end

   assign ready = state_reg == CMIS_ST_READY;

   ////////////////////////////////////////////////////////////////////////
   // Source and scale routing
   always_comb begin
      cfg.enable = mul_ctrl_reg[`CMIS_MUL_EN_BIT];
      cfg.init = mul_ctrl_reg[`CMIS_MUL_INIT_BIT];
      cfg.scale = mul_ctrl_reg[`CMIS_MUL_SCALE_LSB +: 3];
      cfg.sel = cmis_sel_e'(mul_ctrl_reg[`CMIS_MUL_SEL_LSB +: 2]);
   end

   cmis_route u_route (
      .cfg_i(cfg),
      .route_o(route)
   );

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mul_enable_o <= 1'b0;
         mul_use_ext_o <= 1'b0;
         mul_factor_o <= 3'h2;
         scale_num_o <= 3'h1;
         scale_den_o <= 3'h1;
      end else begin
         mul_enable_o <= cfg.enable;
         mul_use_ext_o <= route.use_ext;
         mul_factor_o <= route.mult;
         scale_num_o <= route.num;
         scale_den_o <= route.den;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port pin takeover: 000 off, 01x CMOS, 100 RC, 101 C, 11x crystal
   wire [2:0] mode = osc_ctrl_reg[5:3];
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_claim_o <= '0;
         osc_mode_o <= 3'h0;
         osc_freq_o <= 3'h0;
      end else begin
         pin_claim_o.first_claim <= mode[2:1] == 2'b11;
         pin_claim_o.second_claim <= mode != 3'h0;
         osc_mode_o <= mode;
         osc_freq_o <= osc_ctrl_reg[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_int_x2_unity;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_INT_X2 |=> scale_num_o == 3'h1
         && scale_den_o == 3'h1 && mul_factor_o == 3'h2 && !mul_use_ext_o;
   endproperty
   a_int_x2_unity: assert property (p_int_x2_unity)
      else $error("internal x2 not unity");

   property p_ext_x2;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_EXT_X2 |=> mul_use_ext_o && mul_factor_o == 3'h2;
   endproperty
   a_ext_x2: assert property (p_ext_x2)
      else $error("external x2 wrong");

   property p_int_x4;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_INT_X4 |=> !mul_use_ext_o && mul_factor_o == 3'h4;
   endproperty
   a_int_x4: assert property (p_int_x4)
      else $error("internal x4 wrong");

   property p_ext_x4;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_EXT_X4 |=> mul_use_ext_o && mul_factor_o == 3'h4;
   endproperty
   a_ext_x4: assert property (p_ext_x4)
      else $error("external x4 wrong");

   property p_scale_ignored;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_INT_X2 && cfg.scale == 3'h7 |=> scale_den_o == 3'h1;
   endproperty
   a_scale_ignored: assert property (p_scale_ignored)
      else $error("scale not ignored");

   property p_scale_half;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel != CMIS_SEL_INT_X2 && cfg.scale == 3'h4
         |=> scale_num_o == 3'h1 && scale_den_o == 3'h2;
   endproperty
   a_scale_half: assert property (p_scale_half)
      else $error("scale 100 not one half");

   property p_crystal_pins;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      mode[2:1] == 2'b11 |=> pin_claim_o.first_claim
         && pin_claim_o.second_claim;
   endproperty
   a_crystal_pins: assert property (p_crystal_pins)
      else $error("crystal pins not claimed");

   property p_one_pin;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      mode != 3'h0 && mode[2:1] != 2'b11 |=> !pin_claim_o.first_claim
         && pin_claim_o.second_claim;
   endproperty
   a_one_pin: assert property (p_one_pin)
      else $error("single pin claim wrong");

   property p_init_not_ready;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      init_wr |=> !ready [*2];
   endproperty
   a_init_not_ready: assert property (p_init_not_ready)
      else $error("ready too early after init");

   // Cycles since the last init write while enabled, saturating
   logic [15:0] since_init_reg;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         since_init_reg <= 16'h0000;
      end else if (!mul_ctrl_reg[`CMIS_MUL_EN_BIT]) begin
         since_init_reg <= 16'h0000;
      end else if (init_wr) begin
         since_init_reg <= 16'h0001;
      end else if (since_init_reg != 16'h0000
            && since_init_reg != 16'hffff) begin
         since_init_reg <= since_init_reg + 16'h0001;
      end
   end

   property p_ready_in_time;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      since_init_reg != 16'h0000
         |-> ready == (since_init_reg > SETTLE_CYC);
   endproperty
   a_ready_in_time: assert property (p_ready_in_time)
      else $error("ready not set after settle");

   c_ready: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      $rose(ready));
   c_ext_x4: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cfg.sel == CMIS_SEL_EXT_X4 && cfg.scale == 3'h7);
   c_crystal: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      pin_claim_o.first_claim);
endmodule
`default_nettype wire

// ==== verif/cmis_xosc_model.sv ====
// Behavioural external oscillator that reports valid after start-up in crystal modes
`timescale 1ns/1ns
`default_nettype none
module cmis_xosc_model #(
   parameter int START_NS = 4000
) (
   input wire logic [2:0] mode_i,
   output var logic valid_o
);
   int gen = 0;
   initial valid_o = 1'b0;
   ////////////////////////////////////////////////////////////////////
   // Any mode change restarts start-up; only crystal modes ever settle
   always @(mode_i) begin
      gen++;
      valid_o = 1'b0;
      fork
         begin
            automatic int g = gen;
            #(START_NS);
            if (g == gen && mode_i[2:1] == 2'b11) begin
               valid_o = 1'b1;
            end
         end
      join_none
   end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the clock multiplier input select block
`include "cmis_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cmis_pkg::*;
   typedef struct packed {
      logic en;
      logic ext;
      logic [2:0] fac;
      logic [5:0] ratio;
      logic [1:0] pins;
      logic [2:0] mode;
      logic [2:0] freq;
   } cmis_exp_s;
   logic clk_sys_i, reset_n_i, hsel, hwrite, rd_dp, out_chk, en_s;
   logic hreadyout, hresp, valid, en_o, ext_o;
   logic [1:0] htrans, sel_s;
   logic [2:0] sc_s, md_s, fq_s, fac_o, num_o, den_o, mode_o, freq_o;
   logic [31:0] haddr, hwdata, hrdata, q, d;
   logic [31:0] seed = 32'h0000_6d90;
   cmis_pins_s pins_o;
   cmis_exp_s e;
   logic [63:0] x;
   logic [63:0] rd_q[$];
   cmis_exp_s out_q[$];
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   cmis_top dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .ext_osc_valid_i(valid), .mul_enable_o(en_o),
      .mul_use_ext_o(ext_o), .mul_factor_o(fac_o), .scale_num_o(num_o),
      .scale_den_o(den_o), .pin_claim_o(pins_o), .osc_mode_o(mode_o),
      .osc_freq_o(freq_o));
   cmis_xosc_model xosc_u (.mode_i(mode_o), .valid_o(valid));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] ex,
         input string what);
      cmp_count++;
      if (got !== ex) begin
         n_errors++;
         $display("unexpected at %0t: %s %h vs %h", $time, what, got, ex);
      end
   endtask
   function automatic cmis_exp_s exp_now();
      cmis_exp_s r;
      r.en = en_s;
      r.ext = sel_s[0];
      r.fac = sel_s[1] ? 3'h4 : 3'h2;
      case (sel_s == 2'h0 ? 3'h0 : sc_s)
         3'h3: r.ratio = {3'h2, 3'h3};
         3'h4: r.ratio = {3'h1, 3'h2};
         3'h5: r.ratio = {3'h2, 3'h5};
         3'h6: r.ratio = {3'h1, 3'h3};
         3'h7: r.ratio = {3'h2, 3'h7};
         default: r.ratio = {3'h1, 3'h1};
      endcase
      r.pins = md_s == 3'h0 ? 2'h0 : (md_s[2:1] == 2'h3 ? 2'h3 : 2'h1);
      r.mode = md_s;
      r.freq = fq_s;
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////
   // Bus master and expectation queues
   task automatic bus(input logic wr, input logic [11:0] a,
         input logic [31:0] dd, input logic ck = 1'b1);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h0_0000, a};
      @(posedge clk_sys_i);
      while (hreadyout !== 1'b1) @(posedge clk_sys_i);
      htrans <= 2'h0;
      hwdata <= dd;
      rd_dp <= ~wr & ck;
      @(posedge clk_sys_i);
      while (hreadyout !== 1'b1) @(posedge clk_sys_i);
      q = hrdata;
      rd_dp <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex,
         input logic [31:0] m = 32'hffff_ffff);
      rd_q.push_back({m, ex});
      bus(1'b0, a, rnd());
   endtask
   task automatic sync();
      repeat (3) @(posedge clk_sys_i);
      out_q.push_back(exp_now());
      out_chk <= 1'b1;
      @(posedge clk_sys_i);
      out_chk <= 1'b0;
   endtask
   always @(posedge clk_sys_i) begin
      if (rd_dp && hreadyout) begin
         x = rd_q.pop_front();
         chk(hrdata & x[63:32], x[31:0], "read");
         chk(hresp, 1'b0, "resp");
      end
      if (out_chk) begin
         e = out_q.pop_front();
         chk(en_o, e.en, "enable");
         chk(ext_o, e.ext, "source");
         chk(fac_o, e.fac, "factor");
         chk(32'(num_o) * e.ratio[2:0], 32'(den_o) * e.ratio[5:3],
            "scale");
         chk(pins_o, e.pins, "pins");
         chk({mode_o, freq_o}, {e.mode, e.freq}, "osc");
      end
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      {hsel, hwrite, rd_dp, out_chk, en_s, htrans, sel_s} = '0;
      {sc_s, md_s, fq_s, haddr, hwdata} = '0;
      reset_n_i = 1'b0;
      repeat (20) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      sync();
      rd(`CMIS_OFF_MUL_CTRL, 32'h0);
      rd(`CMIS_OFF_OSC_CTRL, 32'h0);
      rd(`CMIS_OFF_STATUS, 32'h0);
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 8; c++) begin
            {en_s, sel_s, sc_s} = {1'b1, 2'(s), 3'(c)};
            d = {24'h0, 1'b1, 2'h0, sc_s, sel_s};
            bus(1'b1, `CMIS_OFF_MUL_CTRL, (rnd() & 32'hffff_ff20) | d);
            sync();
            rd(`CMIS_OFF_MUL_CTRL, d);
         end
      end
      rd(`CMIS_OFF_STATUS, 32'h1);
      for (int m = 0; m < 8; m++) begin
         {md_s, fq_s} = {3'(m), 3'(rnd())};
         d = {24'h0, 1'b0, md_s, 1'b0, fq_s};
         bus(1'b1, `CMIS_OFF_OSC_CTRL, (rnd() & 32'hffff_ff08) | d);
         sync();
         rd(`CMIS_OFF_OSC_CTRL, d);
      end
      n = 0;
      q = 32'h0;
      while (q[7] !== 1'b1 && n < 100) begin
         bus(1'b0, `CMIS_OFF_OSC_CTRL, 32'h0, 1'b0);
         repeat (20) @(posedge clk_sys_i);
         n++;
      end
      rd(`CMIS_OFF_OSC_CTRL, {24'h0, 1'b1, md_s, 1'b0, fq_s});
      {sel_s, sc_s} = {2'h3, 3'h4};
      bus(1'b1, `CMIS_OFF_MUL_CTRL, 32'h0000_0093);
      sync();
      bus(1'b1, `CMIS_OFF_MUL_CTRL, 32'h0000_00d3);
      rd(`CMIS_OFF_STATUS, 32'h2);
      repeat (`CMIS_SETTLE_CYC - 20) @(posedge clk_sys_i);
      rd(`CMIS_OFF_STATUS, 32'h2);
      repeat (40) @(posedge clk_sys_i);
      rd(`CMIS_OFF_STATUS, 32'h3);
      rd(`CMIS_OFF_MUL_CTRL, 32'h20, 32'h20);
      en_s = 1'b0;
      bus(1'b1, `CMIS_OFF_MUL_CTRL, 32'h0000_0013);
      sync();
      rd(`CMIS_OFF_STATUS, 32'h0);
      rd(`CMIS_OFF_MUL_CTRL, 32'h0, 32'h20);
      bus(1'b1, 12'h00c, rnd());
      sync();
      rd(12'h00c, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
